// >>> rtl/ccr_bus_free_detect.sv
// counter of consecutive recessive bits that flags a free bus
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_bus_free_detect #(
  parameter int BITS = `CCR_BUS_FREE_BITS
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // bit stream
  input  wire logic restart,
  input  wire logic bit_strobe,
  input  wire logic bus_bit,
  // result
  output logic      bus_free
);
  import ccr_pkg::*;

  localparam int CW = $clog2(BITS + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  always_comb begin
    next_count = count;
    if (restart) begin
      next_count = '0;
    end else if (bit_strobe) begin
      if (!bus_bit) begin
        next_count = '0;
      end else if (count != CW'(BITS)) begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count    <= '0;
      bus_free <= 1'h0;
    end else begin
      count    <= next_count;
      bus_free <= (next_count == CW'(BITS));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  dominant_breaks_a: assert property (
    bit_strobe && !bus_bit |=> !bus_free
  ) else $error("bus free after a dominant bit");

  free_needs_run_a: assert property (
    $rose(bus_free) |-> $past(bit_strobe && bus_bit)
  ) else $error("bus free raised without a recessive bit");

endmodule

// >>> rtl/ccr_command_register.sv
// command register of the can controller with its ahb-lite slave
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_command_register #(
  parameter int BUS_FREE_BITS = `CCR_BUS_FREE_BITS
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire ccr_pkg::ccr_addr_type haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire ccr_pkg::ccr_word_type hwdata,
  input  wire logic                  hready,
  output ccr_pkg::ccr_word_type      hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // transfer layer status
  input  wire logic                  tx_in_progress,
  input  wire logic                  tx_start,
  input  wire logic                  tx_success,
  input  wire logic                  overrun_set,
  input  wire logic                  interrupt_pending,
  // bus observation
  input  wire logic                  bus_activity,
  input  wire logic                  bit_strobe,
  input  wire logic                  bus_bit,
  // command pulses to the transfer layer
  output logic                       tx_request_cmd,
  output logic                       abort_tx_cmd,
  output logic                       release_rx_buffer_cmd,
  output logic                       clear_overrun_cmd,
  // flags and states
  output logic                       tx_pending,
  output logic                       tx_complete_flag,
  output logic                       tx_buffer_free_flag,
  output logic                       data_overrun_flag,
  output logic                       sleep_state,
  output logic                       wake_interrupt,
  output logic                       rx_enable,
  // receive comparator control
  output logic                       wake_detect_select,
  output logic                       bus_input_a_connect,
  output logic                       bus_input_b_connect
);
  import ccr_pkg::*;

  function automatic logic is_index(ccr_index_type idx, ccr_index_type want);
    is_index = (idx == want);
  endfunction

  logic          addr_take;
  logic          wr_phase;
  logic          rd_phase;
  logic          rd_is_cmd;
  ccr_index_type wr_index;
  logic          cmd_wr;
  ccr_byte_type  wbyte;
  ccr_byte_type  cmd_view;
  ccr_byte_type  status_view;
  ccr_word_type  next_rdata;
  logic          next_tx_pending;
  logic          sleep_request;
  ccr_power_type power_state;
  ccr_power_type next_power;
  logic          bus_wake;
  logic          bus_free;

  assign addr_take = hsel && hready && htrans[`CCR_HTRANS_ACTIVE];
  assign cmd_wr    = wr_phase && is_index(wr_index, `CCR_CMD_INDEX);
  assign wbyte     = hwdata[7:0];
  assign bus_wake  = (power_state == CCR_ASLEEP) && bus_activity;

  // address phase capture
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_phase  <= 1'h0;
      rd_phase  <= 1'h0;
      rd_is_cmd <= 1'h0;
      wr_index  <= '0;
    end else begin
      wr_phase  <= addr_take && hwrite;
      rd_phase  <= addr_take && !hwrite;
      rd_is_cmd <= is_index(haddr[31:2], `CCR_CMD_INDEX);
      wr_index  <= haddr[31:2];
    end
  end

  // read views
  always_comb begin
    cmd_view = '0;
    cmd_view[`CCR_ACTION_MSB:0] = `CCR_ACTION_ONES;
    cmd_view[`CCR_BIT_SLEEP]     = sleep_state;
    cmd_view[`CCR_BIT_WAKE_SEL]  = wake_detect_select;
    cmd_view[`CCR_BIT_B_CONNECT] = bus_input_b_connect;
    cmd_view[`CCR_BIT_A_CONNECT] = bus_input_a_connect;
    status_view = '0;
    status_view[`CCR_ST_TX_PENDING]  = tx_pending;
    status_view[`CCR_ST_OVERRUN]     = data_overrun_flag;
    status_view[`CCR_ST_TX_COMPLETE] = tx_complete_flag;
    status_view[`CCR_ST_TX_FREE]     = tx_buffer_free_flag;
    status_view[`CCR_ST_RX_ENABLE]   = rx_enable;
    status_view[`CCR_ST_SLEEPING]    = sleep_state;
    next_rdata = '0;
    if (addr_take && !hwrite) begin
      if (is_index(haddr[31:2], `CCR_CMD_INDEX)) begin
        next_rdata = {24'h00_0000, cmd_view};
      end else if (is_index(haddr[31:2], `CCR_STATUS_INDEX)) begin
        next_rdata = {24'h00_0000, status_view};
      end
    end
  end

  // bus answer, zero wait states and always okay
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= '0;
      hreadyout <= `CCR_RST_READY;
      hresp     <= `CCR_RESP_OKAY;
    end else begin
      hrdata    <= next_rdata;
      hreadyout <= `CCR_RST_READY;
      hresp     <= `CCR_RESP_OKAY;
    end
  end

  // one-cycle command pulses
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_request_cmd        <= 1'h0;
      abort_tx_cmd          <= 1'h0;
      release_rx_buffer_cmd <= 1'h0;
      clear_overrun_cmd     <= 1'h0;
    end else begin
      tx_request_cmd        <= cmd_wr && wbyte[`CCR_BIT_TX_REQ];
      abort_tx_cmd          <= cmd_wr && wbyte[`CCR_BIT_ABORT];
      release_rx_buffer_cmd <= cmd_wr && wbyte[`CCR_BIT_RELEASE];
      clear_overrun_cmd     <= cmd_wr && wbyte[`CCR_BIT_CLR_OVR];
    end
  end

  // pending request, abort wins over a request in the same write
  always_comb begin
    next_tx_pending = tx_pending;
    if (tx_start) begin
      next_tx_pending = 1'h0;
    end
    if (cmd_wr && wbyte[`CCR_BIT_TX_REQ]) begin
      next_tx_pending = 1'h1;
    end
    if (cmd_wr && wbyte[`CCR_BIT_ABORT]) begin
      next_tx_pending = 1'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_pending          <= 1'h0;
      tx_buffer_free_flag <= `CCR_RST_TX_FREE;
    end else begin
      tx_pending          <= next_tx_pending;
      tx_buffer_free_flag <= !(next_tx_pending || tx_in_progress);
    end
  end

  // transmission complete flag
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_complete_flag <= 1'h0;
    end else if (tx_success) begin
      tx_complete_flag <= 1'h1;
    end else if (cmd_wr && wbyte[`CCR_BIT_TX_REQ]) begin
      tx_complete_flag <= 1'h0;
    end
  end

  // data overrun flag, a new overrun beats the clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_overrun_flag <= 1'h0;
    end else if (overrun_set) begin
      data_overrun_flag <= 1'h1;
    end else if (cmd_wr && wbyte[`CCR_BIT_CLR_OVR]) begin
      data_overrun_flag <= 1'h0;
    end
  end

  // sleep request and wake mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_request      <= 1'h0;
      wake_detect_select <= 1'h0;
    end else if (cmd_wr) begin
      sleep_request      <= wbyte[`CCR_BIT_SLEEP];
      wake_detect_select <= wbyte[`CCR_BIT_WAKE_SEL];
    end else if (bus_wake) begin
      sleep_request      <= 1'h0;
    end
  end

  // power state
  always_comb begin
    next_power = power_state;
    case (power_state)
      CCR_AWAKE: begin
        if (sleep_request && !interrupt_pending && !bus_activity) begin
          next_power = CCR_ASLEEP;
        end
      end
      CCR_ASLEEP: begin
        if (bus_activity || !sleep_request) begin
          next_power = CCR_AWAKE;
        end
      end
      default: begin
        next_power = CCR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      power_state    <= CCR_AWAKE;
      sleep_state    <= 1'h0;
      wake_interrupt <= 1'h0;
    end else begin
      power_state    <= next_power;
      sleep_state    <= (next_power == CCR_ASLEEP);
      wake_interrupt <= (power_state == CCR_ASLEEP) &&
                        (next_power == CCR_AWAKE);
    end
  end

  // receive enable, withheld after a bus wake until the bus is free
  ccr_bus_free_detect #(
    .BITS       (BUS_FREE_BITS)
  ) u_bus_free (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .restart    (bus_wake),
    .bit_strobe (bit_strobe),
    .bus_bit    (bus_bit),
    .bus_free   (bus_free)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_enable <= `CCR_RST_RX_ENABLE;
    end else if (bus_wake) begin
      rx_enable <= 1'h0;
    end else if (bus_free) begin
      rx_enable <= 1'h1;
    end
  end

  // receive input switches
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_input_a_connect <= `CCR_RST_CONNECT;
      bus_input_b_connect <= `CCR_RST_CONNECT;
    end else if (cmd_wr && (wbyte[`CCR_BIT_A_CONNECT] ||
                            wbyte[`CCR_BIT_B_CONNECT])) begin
      bus_input_a_connect <= wbyte[`CCR_BIT_A_CONNECT];
      bus_input_b_connect <= wbyte[`CCR_BIT_B_CONNECT];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  action_read_one_a: assert property (
    rd_phase && rd_is_cmd |-> hrdata[`CCR_ACTION_MSB:0] == `CCR_ACTION_ONES
  ) else $error("action bits did not read as ones");

  sleep_readback_a: assert property (
    rd_phase && rd_is_cmd |-> hrdata[`CCR_BIT_SLEEP] == $past(sleep_state)
  ) else $error("sleep bit readback differs from state");

  request_pulse_a: assert property (
    cmd_wr && wbyte[`CCR_BIT_TX_REQ] && !wbyte[`CCR_BIT_ABORT]
    |=> tx_request_cmd && tx_pending ##1 !tx_request_cmd || $past(cmd_wr)
  ) else $error("request pulse or pending wrong");

  request_holds_a: assert property (
    tx_pending && !tx_start && !(cmd_wr && wbyte[`CCR_BIT_ABORT])
    |=> tx_pending
  ) else $error("pending request lost without abort");

  abort_cancel_a: assert property (
    cmd_wr && wbyte[`CCR_BIT_ABORT] |=> !tx_pending
  ) else $error("abort did not cancel pending request");

  complete_clear_a: assert property (
    cmd_wr && wbyte[`CCR_BIT_TX_REQ] && !tx_success |=> !tx_complete_flag
  ) else $error("request did not clear complete flag");

  overrun_clear_a: assert property (
    cmd_wr && wbyte[`CCR_BIT_CLR_OVR] && !overrun_set
    |=> !data_overrun_flag
  ) else $error("overrun flag not cleared");

  overrun_keep_a: assert property (
    data_overrun_flag && !(cmd_wr && wbyte[`CCR_BIT_CLR_OVR])
    |=> data_overrun_flag
  ) else $error("overrun flag dropped without command");

  sleep_entry_a: assert property (
    $rose(sleep_state)
    |-> $past(sleep_request && !interrupt_pending && !bus_activity)
  ) else $error("sleep entered while busy");

  wake_flag_a: assert property (
    $fell(sleep_state) |-> wake_interrupt ##1 !wake_interrupt
  ) else $error("wake without one wake interrupt pulse");

  rx_block_a: assert property (
    bus_wake |=> !rx_enable ##1 !rx_enable
  ) else $error("receive enabled right after bus wake");

  switch_keep_a: assert property (
    cmd_wr && !wbyte[`CCR_BIT_A_CONNECT] && !wbyte[`CCR_BIT_B_CONNECT]
    |=> $stable(bus_input_a_connect) && $stable(bus_input_b_connect)
  ) else $error("switches changed on no-action write");

endmodule

// >>> rtl/ccr_consts.svh
// named offsets, bit positions, reset values and counts of the command block
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// word indexes on the bus, byte address is four times the index
`define CCR_CMD_INDEX       30'h0000_0001
`define CCR_STATUS_INDEX    30'h0000_0002

// command register bit positions
`define CCR_BIT_TX_REQ      0
`define CCR_BIT_ABORT       1
`define CCR_BIT_RELEASE     2
`define CCR_BIT_CLR_OVR     3
`define CCR_BIT_SLEEP       4
`define CCR_BIT_WAKE_SEL    5
`define CCR_BIT_B_CONNECT   6
`define CCR_BIT_A_CONNECT   7
`define CCR_ACTION_MSB      3
`define CCR_ACTION_ONES     4'hF

// status register bit positions
`define CCR_ST_TX_PENDING   0
`define CCR_ST_OVERRUN      1
`define CCR_ST_TX_COMPLETE  2
`define CCR_ST_TX_FREE      3
`define CCR_ST_RX_ENABLE    4
`define CCR_ST_SLEEPING     5

// reset values
`define CCR_RST_CONNECT     1'h1
`define CCR_RST_RX_ENABLE   1'h1
`define CCR_RST_TX_FREE     1'h1
`define CCR_RST_READY       1'h1
`define CCR_RESP_OKAY       1'h0

// bus transfer type bit that marks nonseq or seq
`define CCR_HTRANS_ACTIVE   1

// recessive bits that make a bus-free condition
`define CCR_BUS_FREE_BITS   11

`endif

// >>> rtl/ccr_pkg.sv
// types shared by the command block files
package ccr_pkg;

  typedef logic [31:0] ccr_word_type;
  typedef logic [31:0] ccr_addr_type;
  typedef logic [29:0] ccr_index_type;
  typedef logic [7:0]  ccr_byte_type;

  typedef enum logic {
    CCR_AWAKE,
    CCR_ASLEEP
  } ccr_power_type;

endpackage

// >>> tb/can_command_register_logic_tb.sv
// self-checking bench of the command register block
`timescale 1ns/1ps
`include "ccr_consts.svh"
`define CHK(g, e) check_val(32'(g), 32'(e));

module can_command_register_logic_tb;
  import ccr_pkg::*;
  typedef struct {ccr_byte_type wd; ccr_byte_type rd;} ccr_row_type;
  // inputs
  logic         core_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         hsel = 1'b0;
  ccr_addr_type haddr = '0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h2;
  ccr_word_type hwdata = '0;
  logic         overrun_set = 1'b0;
  logic         interrupt_pending = 1'b0;
  logic         bus_activity = 1'b0;
  logic         start_enable = 1'b0;
  logic         bus_level = 1'b1;
  // outputs
  ccr_word_type hrdata;
  ccr_word_type scratch;
  logic         hreadyout, hresp, tx_in_progress, tx_start, tx_success;
  logic         bit_strobe, bus_bit, tx_request_cmd, abort_tx_cmd;
  logic         release_rx_buffer_cmd, clear_overrun_cmd, tx_pending;
  logic         tx_complete_flag, tx_buffer_free_flag, data_overrun_flag;
  logic         sleep_state, wake_interrupt, rx_enable, wake_detect_select;
  logic         bus_input_a_connect, bus_input_b_connect;
  logic [2:0]   sw_view;
  int           err_total = 0;
  int           compares = 0;
  int           pulses [5] = '{0, 0, 0, 0, 0};
  ccr_row_type  rows [6] = '{'{8'h80, 8'h8F}, '{8'h40, 8'h4F},
    '{8'h00, 8'h4F}, '{8'hE0, 8'hEF}, '{8'h20, 8'hEF}, '{8'hC0, 8'hCF}};

  ccr_command_register #(.BUS_FREE_BITS(3)) uut (
    .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_in_progress,
    .tx_start, .tx_success, .overrun_set, .interrupt_pending, .bus_activity,
    .bit_strobe, .bus_bit, .tx_request_cmd, .abort_tx_cmd,
    .release_rx_buffer_cmd, .clear_overrun_cmd, .tx_pending,
    .tx_complete_flag, .tx_buffer_free_flag, .data_overrun_flag,
    .sleep_state, .wake_interrupt, .rx_enable, .wake_detect_select,
    .bus_input_a_connect, .bus_input_b_connect);

  ccr_far_side_model far (
    .core_clk, .rstn, .start_enable, .bus_level, .tx_pending, .tx_start,
    .tx_in_progress, .tx_success, .bit_strobe, .bus_bit);

  always #25 core_clk = ~core_clk;

  assign sw_view = {bus_input_a_connect, bus_input_b_connect,
                    wake_detect_select};

  // cycles high of request, abort, release, clear and wake pulses
  always @(posedge core_clk) begin
    if (tx_request_cmd === 1'b1) pulses[0]++;
    if (abort_tx_cmd === 1'b1) pulses[1]++;
    if (release_rx_buffer_cmd === 1'b1) pulses[2]++;
    if (clear_overrun_cmd === 1'b1) pulses[3]++;
    if (wake_interrupt === 1'b1) pulses[4]++;
  end

  function automatic logic [31:0] pulse_word();
    return {8'(pulses[0]), 8'(pulses[1]), 8'(pulses[2]), 8'(pulses[3])};
  endfunction

  task automatic final_report();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic bus_xfer(input logic wr, input ccr_index_type idx,
                          input ccr_byte_type wd, output ccr_word_type rd);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input ccr_byte_type v);
    ccr_word_type rd;
    bus_xfer(1'b1, `CCR_CMD_INDEX, v, rd);
  endtask

  task automatic rd_chk(input ccr_index_type idx, input ccr_word_type e);
    ccr_word_type rd;
    bus_xfer(1'b0, idx, 8'h00, rd);
    `CHK(rd, e)
  endtask

  task automatic wait_lvl(ref logic s, input logic lvl);
    int n = 0;
    while (s !== lvl && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(s, lvl)
  endtask

  initial begin
    tick(10);
    rstn <= 1'b1;
    tick(1);
    `CHK({hreadyout, hresp, tx_buffer_free_flag, rx_enable}, 4'hB)
    rd_chk(`CCR_CMD_INDEX, 32'hCF);
    rd_chk(`CCR_STATUS_INDEX, 32'h18);
    foreach (rows[i]) begin
      wr(rows[i].wd);
      rd_chk(`CCR_CMD_INDEX, {24'h0, rows[i].rd});
      `CHK(sw_view, rows[i].rd[7:5])
    end
    bus_xfer(1'b1, 30'h3, 8'hFF, scratch);
    rd_chk(30'h3, 32'h0);
    rd_chk(`CCR_CMD_INDEX, 32'hCF);
    `CHK(pulse_word(), 32'h0)
    // request taken and sent, abort arrives too late
    start_enable <= 1'b1;
    wr(8'h01);
    wait_lvl(tx_in_progress, 1'b1);
    wr(8'h01);
    wr(8'h02);
    tick(1);
    `CHK({tx_in_progress, tx_pending}, 2'b10)
    wait_lvl(tx_buffer_free_flag, 1'b1);
    `CHK(tx_complete_flag, 1'b1)
    // request held back, zero write, then abort
    start_enable <= 1'b0;
    wr(8'h01);
    tick(1);
    `CHK({tx_pending, tx_complete_flag}, 2'b10)
    wr(8'h00);
    tick(1);
    `CHK(tx_pending, 1'b1)
    wr(8'h02);
    tick(2);
    `CHK({tx_pending, tx_complete_flag, tx_buffer_free_flag}, 3'b001)
    rd_chk(`CCR_STATUS_INDEX, 32'h18);
    // overrun, zero write, two releases with the clear on the second
    overrun_set <= 1'b1;
    tick(1);
    overrun_set <= 1'b0;
    wr(8'h00);
    tick(1);
    `CHK(data_overrun_flag, 1'b1)
    wr(8'h04);
    tick(2);
    wr(8'h0C);
    tick(1);
    `CHK(data_overrun_flag, 1'b0)
    tick(1);
    `CHK(pulse_word(), 32'h03020201)
    // sleep held off by an interrupt, then woken by software
    interrupt_pending <= 1'b1;
    wr(8'h30);
    tick(4);
    rd_chk(`CCR_CMD_INDEX, 32'hEF);
    interrupt_pending <= 1'b0;
    wait_lvl(sleep_state, 1'b1);
    rd_chk(`CCR_CMD_INDEX, 32'hFF);
    wr(8'h20);
    wait_lvl(sleep_state, 1'b0);
    tick(1);
    `CHK({rx_enable, 8'(pulses[4])}, 9'h101)
    // sleep held off by activity, then woken by the bus
    bus_activity <= 1'b1;
    wr(8'h30);
    tick(4);
    `CHK(sleep_state, 1'b0)
    bus_level <= 1'b0;
    bus_activity <= 1'b0;
    wait_lvl(sleep_state, 1'b1);
    bus_activity <= 1'b1;
    tick(1);
    bus_activity <= 1'b0;
    wait_lvl(sleep_state, 1'b0);
    tick(1);
    `CHK({rx_enable, 8'(pulses[4])}, 9'h002)
    tick(20);
    `CHK(rx_enable, 1'b0)
    bus_level <= 1'b1;
    tick(6);
    `CHK(rx_enable, 1'b0)
    wait_lvl(rx_enable, 1'b1);
    final_report();
  end

  initial begin
    tick(5000);
    err_total++;
    final_report();
  end
endmodule

// >>> tb/ccr_far_side_model.sv
// behavioural transfer layer and sampled bus stream beside the command block
`timescale 1ns/1ps

module ccr_far_side_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // bench controls
  input  wire logic start_enable,
  input  wire logic bus_level,
  // from the command block
  input  wire logic tx_pending,
  // to the command block
  output logic      tx_start,
  output logic      tx_in_progress,
  output logic      tx_success,
  output logic      bit_strobe,
  output logic      bus_bit
);
  logic [3:0] tx_count;
  logic [1:0] bit_phase;

  // takes a waiting request, sends for eight cycles, reports success
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_start       <= 1'b0;
      tx_in_progress <= 1'b0;
      tx_success     <= 1'b0;
      tx_count       <= 4'h0;
    end else begin
      tx_start   <= 1'b0;
      tx_success <= 1'b0;
      if (tx_in_progress) begin
        tx_count <= tx_count - 4'h1;
        if (tx_count == 4'h0) begin
          tx_in_progress <= 1'b0;
          tx_success     <= 1'b1;
        end
      end else if (tx_pending && start_enable) begin
        tx_start       <= 1'b1;
        tx_in_progress <= 1'b1;
        tx_count       <= 4'h7;
      end
    end
  end

  // one strobe every four cycles, the line shows the inverse in between
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_phase  <= 2'h0;
      bit_strobe <= 1'b0;
      bus_bit    <= 1'b1;
    end else begin
      bit_phase  <= bit_phase + 2'h1;
      bit_strobe <= (bit_phase == 2'h3);
      bus_bit    <= (bit_phase == 2'h3) ? bus_level : !bus_level;
    end
  end
endmodule
